/* File: sar_pkg.sv */
// Purpose: Shared constants, states and carriers for the SAR converter control and serial readout
// Assumes: Core clock mclk at 40 MHz
// Notes: Timing counts are derived from times in ns
`default_nettype none
package sar_pkg;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int CNT_W = 5;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   localparam logic [DATA_W-1:0] MSB_MASK = 16'h8000;
   localparam logic [DATA_W-1:0] LSB_MASK = 16'h0001;
   localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam int MCLK_PERIOD_NS = 25;
   // One approximation step; covers comparator settling plus its synchroniser
   localparam int STEP_TIME_NS = 75;
   localparam int STEP_CYC_RAW = (STEP_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int STEP_CYCLES = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_STORE = 2'b10
   } conv_state_e;

   typedef struct packed {
      logic convert_strobe;
      logic daisy_select;
      logic enable_or_chain_in;
      logic sck;
      logic cmp_above;
   } pin_in_s;

   localparam pin_in_s PINS_RESET = '{default: 1'b0};
endpackage
`default_nettype wire

/* File: sar_adc_readout.sv */
// Purpose: Conversion sequencing, result buffering and serial readout of a 16-bit SAR converter
// Assumes: All pins are asynchronous to mclk; SCK much slower than mclk (sampled, not used as clock)
// Notes: Comparator and capacitor DAC are analog; this logic drives the trial code and reads the decision
//
// Contract
// RQ1 - Daisy select low: normal mode, shared pin enables or disables serial output.
// RQ2 - Daisy select high: chain mode, shared pin is the chain serial input.
// RQ3 - Chain mode accepts upstream converter data on the chain input.
// RQ4 - Rising convert strobe wakes from power-down and starts a conversion. Code drops the edge while the result buffer is full.
// RQ5 - Busy rises when conversion starts, falls when it finishes.
// RQ6 - Enabled output shifts result or chained data, one bit per SCK rise, MSB first.
// RQ7 - Result on the serial output is unsigned straight binary.
// RQ8 - Each finished conversion yields a 16-bit word prepared for serial transfer.
// RQ9 - Alternate acquisition (DAC tracks input) and conversion (DAC holds, resolves).
// RQ10 - Successive approximation from half scale down to 1/65536, one bit per step.
// RQ11 - Zero to reference maps onto 2^16 codes; zero input gives code zero.
// RQ12 - Step timing comes from an internal time base, no host conversion clock.
// RQ13 - No restart during conversion; host moves strobe only early or after completion.
// RQ14 - After completion power down and acquire; last result still readable.
// RQ15 - Host starts no conversion for 20 us after power-on reset.
// RQ16 - Normal mode: output driven after enable falls, released after it rises.
// RQ17 - Chain mode: SDI bits captured on SCK rise follow own 16 bits out.
`timescale 1ns/1ps
`default_nettype none

module sar_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [PTR_W:0] cnt_q, cnt_d;
   logic push, pop;

   function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
      ptr_next = (p == PTR_LAST) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      in_ready = (cnt_q != DEPTH_CNT);
      out_valid = (cnt_q != '0);
      out_data = mem_q[rd_q];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? ptr_next(wr_q) : wr_q;
      rd_d = pop ? ptr_next(rd_q) : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; count guards every read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule // sar_word_fifo

module sar_adc_readout
   import sar_pkg::*;
#(
   parameter int WORD_W = DATA_W,
   parameter int BUF_DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Conversion control
   input wire logic convert_strobe,
   output logic busy,
   // Serial port
   input wire logic daisy_select,
   input wire logic enable_or_chain_in,
   input wire logic sck,
   output logic sdo_o,
   output logic sdo_oe,
   // Analog front end
   input wire logic cmp_above,
   output logic [WORD_W-1:0] sampling_cap_dac,
   output logic dac_track
);
   // Two-stage synchroniser; stage one is read only by stage two
   pin_in_s pins_raw, sync1_q, sync2_q, prev_q;

   always_comb begin
      pins_raw.convert_strobe = convert_strobe;
      pins_raw.daisy_select = daisy_select;
      pins_raw.enable_or_chain_in = enable_or_chain_in;
      pins_raw.sck = sck;
      pins_raw.cmp_above = cmp_above;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_q <= PINS_RESET;
         sync2_q <= PINS_RESET;
         prev_q <= PINS_RESET;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   logic cnv_rise, sck_rise;
   assign cnv_rise = sync2_q.convert_strobe && !prev_q.convert_strobe;
   assign sck_rise = sync2_q.sck && !prev_q.sck;

   // Buffer between conversion results and the shifter
   logic [WORD_W-1:0] fifo_out;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic push_q, push_d;
   logic [WORD_W-1:0] result_q, result_d;

   sar_word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rst_n(rst_n),
      .in_data(result_q),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );

   // Conversion sequencer
   conv_state_e state_q, state_d;
   logic [WORD_W-1:0] mask_q, mask_d, dac_q, dac_d;
   logic [CNT_W-1:0] step_q, step_d;
   logic busy_q, busy_d, track_q, track_d;
   logic [WORD_W-1:0] trial_word;

   // Comparator high means the input is at or above the trial level: keep the bit
   function automatic logic [WORD_W-1:0] cmp_decide(input logic [WORD_W-1:0] acc,
                                                   input logic [WORD_W-1:0] bit_mask,
                                                   input logic above);
      cmp_decide = above ? (acc | bit_mask) : acc;
   endfunction

   function automatic logic [WORD_W-1:0] mask_half(input logic [WORD_W-1:0] m);
      mask_half = m >> 1;
   endfunction

   // Shared by the step timer and the bit counter
   function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
      count_down = c - CNT_ONE;
   endfunction

   always_comb begin
      state_d = state_q;
      mask_d = mask_q;
      result_d = result_q;
      dac_d = dac_q;
      step_d = step_q;
      busy_d = busy_q;
      track_d = track_q;
      push_d = 1'b0;
      trial_word = result_q;
      case (state_q)
         ST_ACQUIRE: begin
            // Full buffer refuses the start; the strobe edge is dropped and the converter stays in acquisition
            if (cnv_rise && fifo_in_ready) begin // [RQ4]
               state_d = ST_CONVERT;
               busy_d = 1'b1; // [RQ5]
               track_d = 1'b0; // [RQ9]
               mask_d = MSB_MASK; // [RQ10]
               result_d = ZERO_WORD; // [RQ11]
               dac_d = MSB_MASK;
               step_d = STEP_LAST;
            end
         end
         ST_CONVERT: begin
            // Strobe edges are ignored here, so a conversion never restarts
            if (step_q == CNT_ZERO) begin // [RQ12] [RQ13]
               trial_word = cmp_decide(result_q, mask_q, sync2_q.cmp_above);
               result_d = trial_word; // [RQ10]
               mask_d = mask_half(mask_q);
               dac_d = trial_word | mask_half(mask_q);
               step_d = STEP_LAST;
               if (mask_q == LSB_MASK) begin
                  state_d = ST_STORE;
                  dac_d = trial_word;
               end
            end else begin
               step_d = count_down(step_q);
            end
         end
         ST_STORE: begin
            push_d = 1'b1; // [RQ8]
            busy_d = 1'b0; // [RQ5]
            track_d = 1'b1; // [RQ14] [RQ9]
            state_d = ST_ACQUIRE;
         end
         default: begin
            state_d = ST_ACQUIRE;
            busy_d = 1'b0;
            track_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ST_ACQUIRE;
         mask_q <= ZERO_WORD;
         result_q <= ZERO_WORD;
         dac_q <= ZERO_WORD;
         step_q <= CNT_ZERO;
         busy_q <= 1'b0;
         track_q <= 1'b1;
         push_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mask_q <= mask_d;
         result_q <= result_d;
         dac_q <= dac_d;
         step_q <= step_d;
         busy_q <= busy_d;
         track_q <= track_d;
         push_q <= push_d;
      end
   end

   // Serial shifter; its low end takes the chain input, so upstream data trails our word
   logic [WORD_W-1:0] shreg_q, shreg_d;
   logic [CNT_W-1:0] left_q, left_d;
   logic sdo_q, sdo_d, oe_q, oe_d, chain_bit;

   always_comb begin
      shreg_d = shreg_q;
      left_d = left_q;
      fifo_pop = 1'b0;
      chain_bit = sync2_q.daisy_select ? sync2_q.enable_or_chain_in : 1'b0; // [RQ2] [RQ3]
      // Normal mode: shared pin is the active-low enable
      oe_d = sync2_q.daisy_select || !sync2_q.enable_or_chain_in; // [RQ1] [RQ16]
      if (sck_rise && oe_q) begin
         shreg_d = {shreg_q[WORD_W-2:0], chain_bit}; // [RQ6] [RQ17]
         if (left_q != CNT_ZERO) begin
            left_d = count_down(left_q);
         end
      end else if (left_q == CNT_ZERO && fifo_out_valid) begin
         // New word only once the previous one is fully shifted
         shreg_d = fifo_out; // [RQ7]
         left_d = BITS_PER_WORD;
         fifo_pop = 1'b1;
      end
      sdo_d = shreg_d[WORD_W-1]; // [RQ6]
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shreg_q <= ZERO_WORD;
         left_q <= CNT_ZERO;
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         shreg_q <= shreg_d;
         left_q <= left_d;
         sdo_q <= sdo_d;
         oe_q <= oe_d;
      end
   end

   assign busy = busy_q;
   assign sdo_o = sdo_q;
   assign sdo_oe = oe_q;
   assign sampling_cap_dac = dac_q;
   assign dac_track = track_q;
endmodule // sar_adc_readout
`default_nettype wire

/* File: sar_adc_readout_asserts.sv */
// Purpose: Port checks for conversion and readout
// Assumes: Mode pins settle within 5 mclk
// Notes: Busy width is 16 steps of 3 plus one store cycle
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout_chk #(
   parameter int WORD_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control and serial pins
   input wire logic convert_strobe,
   input wire logic busy,
   input wire logic daisy_select,
   input wire logic enable_or_chain_in,
   input wire logic sck,
   input wire logic sdo_oe,
   // Analog side
   input wire logic [WORD_W-1:0] sampling_cap_dac,
   input wire logic dac_track
);
   logic [6:0] bcnt_q;
   logic [6:0] bcnt_d;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   always_comb begin
      bcnt_d = (rst_n && busy) ? bcnt_q + 7'h01 : 7'h00;
   end
   always_ff @(posedge mclk) begin
      bcnt_q <= bcnt_d;
   end
   a_busy_exact: assert property ($fell(busy) |-> bcnt_q == 7'h31) else $error("busy width");
   a_busy_bound: assert property (bcnt_q <= 7'h31) else $error("busy too long");
   a_track_phase: assert property (dac_track == !busy) else $error("track phase");
   a_first_trial: assert property ($rose(busy) |-> sampling_cap_dac == {1'b1, {(WORD_W-1){1'b0}}})
      else $error("first trial");
   a_start_cause: assert property ($rose(busy) |->
      $past(convert_strobe, 2) || $past(convert_strobe, 3) || $past(convert_strobe, 4)) else $error("stray start");
   a_trial_hold: assert property (busy && $past(busy) && $changed(sampling_cap_dac) |=>
      $stable(sampling_cap_dac)[*2]) else $error("step too short");
   a_oe_enabled: assert property ((!daisy_select && !enable_or_chain_in)[*5] |-> sdo_oe) else $error("not driven");
   a_oe_released: assert property ((!daisy_select && enable_or_chain_in)[*5] |-> !sdo_oe) else $error("not released");
   a_chain_driven: assert property (daisy_select[*5] |-> sdo_oe) else $error("chain output off");
   c_conv_done: cover property ($fell(busy));
   c_read_frame: cover property (sdo_oe && !daisy_select && $rose(sck));
   c_chain_shift: cover property (daisy_select && $rose(sck));
endmodule // sar_adc_readout_chk
bind sar_adc_readout sar_adc_readout_chk #(.WORD_W(WORD_W)) sar_adc_readout_chk_inst (.mclk(mclk), .rst_n(rst_n),
   .convert_strobe(convert_strobe), .busy(busy), .daisy_select(daisy_select), .sck(sck), .sdo_oe(sdo_oe),
   .enable_or_chain_in(enable_or_chain_in), .sampling_cap_dac(sampling_cap_dac), .dac_track(dac_track));
`default_nettype wire

/* File: sar_host_model.sv */
// Purpose: Host side of the serial port, frames of rising shift edges
// Assumes: Shift clock period 200 ns, idle low between frames
// Notes: Released output reads back inverted so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
   // Serial port
   output var logic sck,
   output var logic enable_or_chain_in,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic last_q;
   logic sdo_wire;
   initial begin
      sck = 1'b0;
      enable_or_chain_in = 1'b1;
      last_q = 1'b0;
   end
   always @(sdo_o or sdo_oe) begin
      if (sdo_oe) begin
         last_q = sdo_o;
      end
   end
   assign sdo_wire = sdo_oe ? sdo_o : ~last_q;
   task automatic xfer(input logic chain, input logic en_off, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      dout = 32'h0;
      #31;
      enable_or_chain_in = chain ? din[n-1] : en_off;
      #100;
      for (int i = 0; i < n; i++) begin
         if (chain) begin
            enable_or_chain_in = din[n-1-i];
         end
         #100;
         dout = {dout[30:0], sdo_wire};
         sck = 1'b1;
         #100;
         sck = 1'b0;
      end
      #100;
      enable_or_chain_in = 1'b1;
   endtask
endmodule // sar_host_model
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench for conversion and serial readout
// Assumes: Ideal comparator against vin
// Notes: Frames come from the host model
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sar_pkg::*;
   logic mclk, rst_n, convert_strobe, daisy_select, busy, sdo_o, sdo_oe, dac_track, sck, enable_or_chain_in;
   logic cmp_above;
   logic [DATA_W-1:0] dac;
   logic [DATA_W-1:0] vin;
   logic [DATA_W-1:0] exp_q[$];
   logic [31:0] d;
   int failures, num_checks, len;
   assign cmp_above = (vin >= dac);
   sar_adc_readout #(.WORD_W(DATA_W), .BUF_DEPTH(FIFO_DEPTH)) sar_adc_readout_inst (.mclk(mclk), .rst_n(rst_n),
      .convert_strobe(convert_strobe), .busy(busy), .daisy_select(daisy_select), .sck(sck), .sdo_o(sdo_o),
      .enable_or_chain_in(enable_or_chain_in), .sdo_oe(sdo_oe), .cmp_above(cmp_above), .sampling_cap_dac(dac),
      .dac_track(dac_track));
   sar_host_model sar_host_model_inst (.sck(sck), .enable_or_chain_in(enable_or_chain_in), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_count(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Busy spans one step per result bit plus the store cycle
   function automatic int exp_busy_cycles();
      return DATA_W * STEP_CYCLES + 1;
   endfunction
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // One-cycle strobe; again adds a stray edge mid-conversion
   task automatic convert(input logic [DATA_W-1:0] v, input logic again);
      int k;
      len = 0;
      k = 0;
      @(negedge mclk);
      vin = v;
      convert_strobe = 1'b1;
      @(negedge mclk);
      convert_strobe = 1'b0;
      while (busy !== 1'b1 && k < 8) begin
         @(negedge mclk);
         k++;
      end
      while (busy === 1'b1 && len < 60) begin
         @(negedge mclk);
         convert_strobe = again && len == 10;
         len++;
      end
      repeat (4) @(negedge mclk);
   endtask
   initial begin
      logic [DATA_W-1:0] v;
      logic [DATA_W-1:0] w;
      failures = 0;
      num_checks = 0;
      rst_n = 1'b0;
      convert_strobe = 1'b0;
      daisy_select = 1'b0;
      vin = 16'h0000;
      void'($urandom(44529));
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      repeat (800) @(negedge mclk);
      chk_flag(sdo_oe, 1'b0);
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : (i == 2) ? 16'h8000 : (i == 3) ? 16'h7FFF : 16'($urandom);
         convert(v, 1'b0);
         chk_count(len, exp_busy_cycles());
         sar_host_model_inst.xfer(1'b0, 1'b1, 4, 32'h0, d);
         sar_host_model_inst.xfer(1'b0, 1'b0, 16, 32'h0, d);
         chk_word(d, {16'h0, v});
      end
      $display("test single_conversions done");
      for (int i = 0; i < 6; i++) begin
         exp_q.push_back(16'($urandom));
         convert(exp_q[i], i == 0);
         chk_count(len, (i < FIFO_DEPTH + 1) ? exp_busy_cycles() : 0);
      end
      for (int i = 0; i < 5; i++) begin
         sar_host_model_inst.xfer(1'b0, 1'b0, 16, 32'h0, d);
         chk_word(d, {16'h0, exp_q[i]});
      end
      // Refused conversion must not surface: shifter runs dry with zeros
      sar_host_model_inst.xfer(1'b0, 1'b0, 16, 32'h0, d);
      chk_word(d, 32'h0);
      $display("test buffer_full done");
      @(negedge mclk);
      daisy_select = 1'b1;
      repeat (8) @(negedge mclk);
      chk_flag(sdo_oe, 1'b1);
      v = 16'($urandom);
      w = 16'($urandom);
      convert(v, 1'b0);
      sar_host_model_inst.xfer(1'b1, 1'b0, 32, {w, 16'h0}, d);
      chk_word(d, {v, w});
      $display("test chain_mode done");
      end_of_test();
   end
endmodule // tb
`default_nettype wire
